// ==== include/cps_pkg.sv ====
// Operation
// - Three straps pick one of eight pages
// - Delay 100 ms when low, 2 ms high
// - Hold reset until supply good, counter expired
// - Enable line held low extends reset
// - Target status low restarts reset and configuration
// - Done low after data sent forces reconfiguration
// - Done-sense high at release parks in idle
// - Idle left only by power cycle
// - External clock ignored once target in user mode
`default_nettype none
package cps_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CPS_CLK_HZ = 50000000;
    localparam int CPS_LONG_MS = 100;
    localparam int CPS_SHORT_MS = 2;
    localparam int CPS_MS_PER_S = 1000;
    localparam int CPS_LONG_CYC = CPS_CLK_HZ / CPS_MS_PER_S * CPS_LONG_MS;
    localparam int CPS_SHORT_CYC = CPS_CLK_HZ / CPS_MS_PER_S * CPS_SHORT_MS;
    localparam int CPS_CNT_W = 23;
    localparam int CPS_PAGE_W = 3;
    localparam logic [CPS_PAGE_W-1:0] CPS_PAGE_RST = 3'h0;
    localparam logic [1:0] CPS_DIV_RST = 2'h0;

    typedef enum logic [2:0] {
        CPS_POR,
        CPS_HOLD,
        CPS_CONFIG,
        CPS_USER,
        CPS_IDLE
    } cps_state_t;
endpackage
`default_nettype wire

// ==== verilog/cps_config_por_start_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module cps_config_por_start_control
    import cps_pkg::*;
#(
    parameter int LONG_CYC = CPS_LONG_CYC,
    parameter int SHORT_CYC = CPS_SHORT_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic supply_good,
    input wire logic por_delay_select,
    input wire logic [CPS_PAGE_W-1:0] page_select,
    input wire logic enable_in,
    output logic enable_out,
    output logic enable_oe,
    input wire logic done_sense_input,
    input wire logic target_status,
    input wire logic target_done,
    input wire logic data_sent,
    input wire logic use_external_clock,
    input wire logic external_clock_in,
    output logic config_clock_out,
    output logic config_active,
    output logic [CPS_PAGE_W-1:0] page_q,
    output logic por_done,
    output logic idle_parked
);
    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    cps_state_t state_q, state_d;
    logic [CPS_CNT_W-1:0] cnt_q, cnt_d;
    logic [CPS_PAGE_W-1:0] page_d;
    logic oe_q, oe_d;
    logic clk_q, clk_d;
    logic [1:0] div_q, div_d;
    logic [CPS_CNT_W-1:0] term;
    logic act_d, done_d, idle_d;

    // Counter runs on sys_clk, the free-running source
    assign term = por_delay_select ? CPS_CNT_W'(SHORT_CYC - 1) : CPS_CNT_W'(LONG_CYC - 1);

    // A failed target or a sagging supply both send the sequence back to reset
    function automatic logic restart_req(input logic status_line, input logic supply_ok);
        return !status_line || !supply_ok;
    endfunction

    // Output flags are decoded from the next state so they line up with state_q
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        page_d = page_q;
        oe_d = oe_q;
        div_d = div_q;
        clk_d = 1'b0;
        case (state_q)
            CPS_POR: begin
                // Every entry here reruns the whole selected delay
                oe_d = 1'b1;
                if (!supply_good) begin
                    cnt_d = '0;
                end else if (cnt_q >= term) begin
                    oe_d = 1'b0;
                    state_d = CPS_HOLD;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            CPS_HOLD: begin
                // Release seen only when the pull-up wins; others may hold low
                if (!supply_good) begin
                    state_d = CPS_POR;
                    cnt_d = '0;
                    oe_d = 1'b1;
                end else if (enable_in) begin
                    page_d = page_select;
                    if (done_sense_input) begin
                        state_d = CPS_IDLE;
                    end else begin
                        state_d = CPS_CONFIG;
                    end
                end
            end
            CPS_CONFIG: begin
                div_d = div_q + 1'b1;
                clk_d = use_external_clock ? external_clock_in : div_q[1];
                if (restart_req(target_status, supply_good)) begin
                    state_d = CPS_POR;
                    cnt_d = '0;
                    oe_d = 1'b1;
                end else if (data_sent) begin
                    if (target_done) begin
                        state_d = CPS_USER;
                    end else begin
                        state_d = CPS_POR;
                        cnt_d = '0;
                        oe_d = 1'b1;
                    end
                end
            end
            CPS_USER: begin
                // External clock no longer reaches the output here
                clk_d = 1'b0;
                if (restart_req(target_status, supply_good)) begin
                    state_d = CPS_POR;
                    cnt_d = '0;
                    oe_d = 1'b1;
                end
            end
            CPS_IDLE: begin
                state_d = CPS_IDLE;
            end
            default: begin
                state_d = CPS_POR;
                cnt_d = '0;
                oe_d = 1'b1;
            end
        endcase
        act_d = (state_d == CPS_CONFIG);
        // Test-port gate for the outside party
        done_d = (state_d != CPS_POR) && (state_d != CPS_HOLD);
        idle_d = (state_d == CPS_IDLE);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= CPS_POR;
            cnt_q <= '0;
            page_q <= CPS_PAGE_RST;
            oe_q <= 1'b1;
            clk_q <= 1'b0;
            div_q <= CPS_DIV_RST;
            config_active <= 1'b0;
            por_done <= 1'b0;
            idle_parked <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            page_q <= page_d;
            oe_q <= oe_d;
            clk_q <= clk_d;
            div_q <= div_d;
            config_active <= act_d;
            por_done <= done_d;
            idle_parked <= idle_d;
        end
    end

    // ---------------------------------------------------------------
    // Pins
    // ---------------------------------------------------------------
    // Open drain: the line is only ever pulled low, the pull-up releases it
    assign enable_out = 1'b0;
    assign enable_oe = oe_q;
    assign config_clock_out = clk_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Idle parking: only a reset, standing for a power cycle, leaves it
    AST_IDLE_STICKY: assert property (state_q == CPS_IDLE |=> state_q == CPS_IDLE)
        else $error("idle state left");
    AST_IDLE_LINE: assert property (state_q == CPS_IDLE |=> !enable_oe && idle_parked && por_done)
        else $error("idle line or flag changed");
    AST_IDLE_ENTRY: assert property (
        state_q == CPS_HOLD && enable_in && done_sense_input && supply_good |=> idle_parked)
        else $error("done-sense high did not park");
    AST_CONFIG_ENTRY: assert property (
        state_q == CPS_HOLD && enable_in && !done_sense_input && supply_good |=> config_active && por_done)
        else $error("done-sense low did not start");
    AST_IDLE_QUIET: assert property (state_q == CPS_IDLE |=> !config_clock_out && !config_active)
        else $error("clock toggles in idle");

    AST_HOLD_LOW: assert property (state_q == CPS_HOLD && !enable_in |=> !por_done)
        else $error("reset ended while line low");
    AST_STATUS_RESTART: assert property (
        state_q == CPS_CONFIG && !target_status |=> enable_oe && state_q == CPS_POR)
        else $error("status low ignored");
    AST_USER_RESTART: assert property (
        state_q == CPS_USER && !target_status |=> enable_oe && state_q == CPS_POR && !por_done)
        else $error("status low ignored in user mode");
    AST_DONE_ERROR: assert property (
        state_q == CPS_CONFIG && target_status && supply_good && data_sent && !target_done |=> enable_oe)
        else $error("missing done not forced");
    AST_DONE_OK: assert property (
        state_q == CPS_CONFIG && target_status && supply_good && data_sent && target_done
        |=> !enable_oe && state_q == CPS_USER)
        else $error("good done forced a retry");
    AST_PAGE_LATCH: assert property (
        state_q == CPS_HOLD && enable_in && supply_good |=> page_q == $past(page_select))
        else $error("page not latched");
    AST_PAGE_STABLE: assert property (state_q == CPS_CONFIG |=> $stable(page_q))
        else $error("page changed during configuration");

    AST_POR_HOLD: assert property (state_q == CPS_POR |-> enable_oe && !por_done)
        else $error("line released during count");
    AST_SUPPLY_CLEAR: assert property (state_q == CPS_POR && !supply_good |=> enable_oe && cnt_q == '0)
        else $error("counter ran without supply");
    AST_SHORT_DELAY: assert property (
        state_q == CPS_POR && supply_good && por_delay_select && cnt_q == CPS_CNT_W'(SHORT_CYC - 1) |=> !enable_oe)
        else $error("short delay wrong");
    AST_LONG_DELAY: assert property (
        state_q == CPS_POR && supply_good && !por_delay_select && cnt_q == CPS_CNT_W'(LONG_CYC - 1)
        |=> !enable_oe)
        else $error("long delay wrong");
    AST_EARLY_RELEASE: assert property (
        state_q == CPS_POR && cnt_q < CPS_CNT_W'(SHORT_CYC - 1) |=> enable_oe)
        else $error("line released before short delay");

    AST_EXT_CLK: assert property (state_q == CPS_CONFIG && use_external_clock
        |=> config_clock_out == $past(external_clock_in))
        else $error("external clock not passed");
    AST_USER_CLK: assert property (state_q == CPS_USER |=> !config_clock_out)
        else $error("clock in user mode");

    COV_CONFIG: cover property (state_q == CPS_HOLD ##1 state_q == CPS_CONFIG);
    COV_IDLE: cover property (state_q == CPS_HOLD ##1 state_q == CPS_IDLE);
    COV_USER: cover property (state_q == CPS_CONFIG ##1 state_q == CPS_USER);
    COV_RETRY: cover property (state_q == CPS_CONFIG ##1 state_q == CPS_POR);
    COV_EXT_CLK: cover property (state_q == CPS_CONFIG && use_external_clock ##1 config_clock_out);
endmodule
`default_nettype wire

// ==== verification/cps_target_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Shared enable line with pull-up
// ---------------------------------------------------------------
module cps_target_model (
    input wire logic enable_oe,
    input wire logic hold_low,
    output logic enable_in
);
    // Either party pulling low wins; the pull-up raises it otherwise
    assign enable_in = !(enable_oe || hold_low);
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cps_pkg::*;
    localparam int LC = 40;
    localparam int SC = 8;
    localparam int CLK_NS = 20;
    localparam int WD_NS = CLK_NS * 4 * (3 * LC + 4 * SC + 60);
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic sg = 1'b0, sel = 1'b1, hold = 1'b1, dsi = 1'b0, tst = 1'b1, tdn = 1'b0, sent = 1'b0;
    logic uxc = 1'b0, xclk = 1'b0, en_in, en_out, oe, cco, act, pd, idl, v;
    logic [CPS_PAGE_W-1:0] pg = 3'h5, pq;
    int failures = 0, tests_run = 0, n;
    cps_config_por_start_control #(.LONG_CYC(LC), .SHORT_CYC(SC)) i_cps_config_por_start_control (
        .sys_clk(sys_clk), .reset(reset), .supply_good(sg), .por_delay_select(sel), .page_select(pg),
        .enable_in(en_in), .enable_out(en_out), .enable_oe(oe), .done_sense_input(dsi),
        .target_status(tst), .target_done(tdn), .data_sent(sent), .use_external_clock(uxc),
        .external_clock_in(xclk), .config_clock_out(cco), .config_active(act), .page_q(pq),
        .por_done(pd), .idle_parked(idl));
    cps_target_model i_cps_target_model (.enable_oe(oe), .hold_low(hold), .enable_in(en_in));
    initial forever #(CLK_NS / 2) sys_clk = ~sys_clk;
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_oe(input int exp);
        n = 0;
        while (oe !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        check("por_len", 8'(n), 8'(exp));
    endtask
    task automatic pulse_sent();
        sent = 1'b1;
        tick(1);
        sent = 1'b0;
    endtask
    task automatic give_verdict();
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #(WD_NS);
        failures++;
        give_verdict();
    end
    initial begin
        tick(4);
        check("oe_rst", 8'(oe), 8'h1);
        check("pd_rst", 8'(pd), 8'h0);
        check("en_out", 8'(en_out), 8'h0);
        check("pg_rst", 8'(pq), 8'h0);
        reset = 1'b0;
        tick(SC + 2);
        check("nosup_oe", 8'(oe), 8'h1);
        check("nosup_pd", 8'(pd), 8'h0);
        sg = 1'b1;
        tick(SC / 2);
        sg = 1'b0;
        tick(1);
        sg = 1'b1;
        wait_oe(SC);
        tick(3);
        check("held_pd", 8'(pd), 8'h0);
        check("held_act", 8'(act), 8'h0);
        hold = 1'b0;
        tick(2);
        check("act", 8'(act), 8'h1);
        check("page", 8'(pq), 8'h5);
        check("rel_pd", 8'(pd), 8'h1);
        v = cco;
        tick(2);
        check("clk_tgl", 8'(cco), 8'(!v));
        uxc = 1'b1;
        xclk = 1'b1;
        tick(1);
        check("ext_hi", 8'(cco), 8'h1);
        xclk = 1'b0;
        tick(1);
        check("ext_lo", 8'(cco), 8'h0);
        uxc = 1'b0;
        pulse_sent();
        check("err_oe", 8'(oe), 8'h1);
        check("err_act", 8'(act), 8'h0);
        sel = 1'b0;
        pg = 3'h2;
        wait_oe(LC);
        tick(2);
        check("page2", 8'(pq), 8'h2);
        tst = 1'b0;
        tick(1);
        check("stat_oe", 8'(oe), 8'h1);
        check("stat_act", 8'(act), 8'h0);
        tst = 1'b1;
        wait_oe(LC);
        tick(2);
        tdn = 1'b1;
        uxc = 1'b1;
        pulse_sent();
        tick(1);
        check("user_act", 8'(act), 8'h0);
        check("user_pd", 8'(pd), 8'h1);
        check("user_oe", 8'(oe), 8'h0);
        v = cco;
        repeat (6) begin
            xclk = ~xclk;
            tick(1);
        end
        check("user_clk", 8'(cco), 8'(v));
        tst = 1'b0;
        tick(1);
        check("user_stat", 8'(oe), 8'h1);
        tst = 1'b1;
        reset = 1'b1;
        dsi = 1'b1;
        sel = 1'b1;
        tick(2);
        check("rst2_oe", 8'(oe), 8'h1);
        check("rst2_pd", 8'(pd), 8'h0);
        reset = 1'b0;
        wait_oe(SC);
        tick(2);
        check("idle", 8'(idl), 8'h1);
        check("idle_act", 8'(act), 8'h0);
        v = cco;
        tst = 1'b0;
        tdn = 1'b0;
        pulse_sent();
        repeat (3) begin
            xclk = ~xclk;
            tick(1);
        end
        check("idle_hold", 8'(idl), 8'h1);
        check("idle_oe", 8'(oe), 8'h0);
        check("idle_clk", 8'(cco), 8'(v));
        give_verdict();
    end
endmodule
`default_nettype wire
